/* File: rtl/serial_eeprom_controller.sv */
// Purpose: station address auto-load and host commands for a three-wire 128 x 8 serial memory
// Assumes: host keeps busy-bit handshake; data pin is one shared wire
// Notes:   serial clock made here by division, no second clock domain
`include "serial_mem_cfg.svh"

module serial_eeprom_controller
  import serial_mem_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `RESP_TIMEOUT_CYCLES,
  parameter int          SCLK_HALF      = `SCLK_HALF_CYCLES
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // host command side
  input  wire logic         soft_reset_req,
  input  host_cmd_type      operation_code_field,
  input  wire logic [6:0]   location_field,
  input  wire logic         cmd_start,
  input  wire logic         data_wr_en,
  input  wire logic [7:0]   data_wr_value,
  input  wire logic         timeout_clear,
  // interface enable and general-purpose pin values
  input  wire logic         if_enable,
  input  wire logic         gpio_data_val,
  input  wire logic         gpio_clk_val,
  // status and stored values
  output logic              operation_busy_bit,
  output logic              response_timeout_bit,
  output logic              station_addr_loaded_bit,
  output logic      [7:0]   serial_mem_data_reg,
  output logic      [31:0]  station_addr_lower,
  output logic      [15:0]  station_addr_upper,
  // serial memory pins
  output logic              serial_mem_clock_pin,
  output logic              serial_mem_select_pin,
  output logic              serial_mem_data_out,
  output logic              serial_mem_data_oe_n,
  input  wire logic         serial_mem_data_in
);

  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

  ctl_state_type state, next_state;       // controller state
  host_cmd_type  cur, next_cur;           // command being run
  logic [17:0]   tx, next_tx;             // outgoing frame, msb first
  logic [4:0]    frame_len, next_len;     // serial clocks in this frame
  logic [4:0]    bit_cnt, next_bit_cnt;   // serial rises seen
  logic [7:0]    rx, next_rx;             // incoming read data
  logic [TO_W-1:0] to_cnt, next_to_cnt;   // response timer
  logic          aborted, next_aborted;   // frame ended by timeout
  logic          load_pend, next_load_pend; // auto-load waiting to start
  logic          load_run, next_load_run; // auto-load sequence active
  logic [2:0]    load_idx, next_load_idx; // 0 signature, 1..6 address bytes
  logic          cs, next_cs;             // select level wanted
  logic          dout, next_dout;         // data level wanted
  logic          doe_n, next_doe_n;       // data drive wanted, low drives
  logic [7:0]    next_data;               // next data register
  logic [31:0]   next_lo;                 // next station address low
  logic [15:0]   next_hi;                 // next station address high
  logic          next_loaded, next_timeout, next_busy;
  logic          launch_go;               // start a frame this cycle
  host_cmd_type  launch_cmd;              // command of that frame
  logic [6:0]    launch_addr;             // location of that frame
  logic [17:0]   launch_frame;            // built frame
  logic          din;                     // synchronised data pin
  logic          sclk, rise, fall;        // divided clock and edges
  logic          next_clk_pin, next_cs_pin, next_dout_pin, next_oe_pin;

  // build a serial frame: start bit, opcode, 7-bit address, data
  function automatic logic [17:0] build_frame(input host_cmd_type c, input logic [6:0] a,
                                              input logic [7:0] d);
    case (c)
      read_cmd:             build_frame = {1'b1, `OP_READ, a, 8'h00};
      write_cmd:            build_frame = {1'b1, `OP_WRITE, a, d};
      erase_cmd:            build_frame = {1'b1, `OP_ERASE, a, 8'h00};
      modify_enable_cmd:    build_frame = {1'b1, `OP_EXT, `EXT_MODIFY_ENABLE_CMD, 5'h00, 8'h00};
      modify_disable_cmd:   build_frame = {1'b1, `OP_EXT, `EXT_MODIFY_DISABLE_CMD, 5'h00, 8'h00};
      erase_everything_cmd: build_frame = {1'b1, `OP_EXT, `EXT_ERASE_EVERYTHING_CMD, 5'h00, 8'h00};
      write_everything_cmd: build_frame = {1'b1, `OP_EXT, `EXT_WRITE_EVERYTHING_CMD, 5'h00, d};
      default:              build_frame = 18'h00000;
    endcase
  endfunction

  // commands that carry eight data bits
  function automatic logic is_long(input host_cmd_type c);
    is_long = (c == read_cmd) || (c == write_cmd) || (c == write_everything_cmd);
  endfunction

  // commands whose completion is polled on the data pin
  function automatic logic needs_poll(input host_cmd_type c);
    needs_poll = (c == write_cmd) || (c == write_everything_cmd) || (c == erase_cmd) ||
                 (c == erase_everything_cmd);
  endfunction

  // data pin into the clock domain
  pin_sync #(.WIDTH(1)) u_din_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (serial_mem_data_in),
    .sync_out (din)
  );

  // serial clock runs only while a frame or gap is timed
  serial_clk_gen #(.HALF_CYCLES(SCLK_HALF)) u_sclk (
    .clk   (clk),
    .rst_n (rst_n),
    .run   ((state == st_shift) || (state == st_gap)),
    .sclk  (sclk),
    .rise  (rise),
    .fall  (fall)
  );

  // controller next-state logic
  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_tx        = tx;
    next_len       = frame_len;
    next_bit_cnt   = bit_cnt;
    next_rx        = rx;
    next_aborted   = aborted;
    next_load_pend = load_pend;
    next_load_run  = load_run;
    next_load_idx  = load_idx;
    next_cs        = cs;
    next_dout      = dout;
    next_doe_n     = doe_n;
    next_data      = serial_mem_data_reg;
    next_lo        = station_addr_lower;
    next_hi        = station_addr_upper;
    next_loaded    = station_addr_loaded_bit;
    next_timeout   = response_timeout_bit;
    launch_go      = 1'b0;
    launch_cmd     = read_cmd;
    launch_addr    = `SIG_ADDR;
    next_to_cnt    = (state == st_idle) ? '0 : to_cnt + TO_W'(1);
    if (timeout_clear) begin
      next_timeout = 1'b0;
    end
    // host writes the data register only while idle
    if (data_wr_en && !operation_busy_bit) begin
      next_data = data_wr_value;
    end
    if (soft_reset_req) begin
      next_load_pend = 1'b1;
    end
    case (state)
      st_idle: begin
        next_aborted = 1'b0;
        if (load_pend) begin
          // auto-load starts with the signature byte
          next_load_pend = 1'b0;
          next_load_run  = 1'b1;
          next_load_idx  = 3'h0;
          next_loaded    = 1'b0;
          launch_go      = 1'b1;
        end else if (cmd_start && if_enable) begin
          if (operation_code_field == reload_cmd) begin
            next_load_pend = 1'b1;
          end else begin
            launch_go   = 1'b1;
            launch_cmd  = operation_code_field;
            launch_addr = location_field;
          end
        end
      end
      st_shift: begin
        if (rise) begin
          next_bit_cnt = bit_cnt + 5'h01;
        end
        if (fall) begin
          // read data is taken on falls after rises 11 to 18
          if (cur == read_cmd && bit_cnt >= `FIRST_SAMPLE_BIT) begin
            next_rx = {rx[6:0], din};
          end
          if (bit_cnt == frame_len) begin
            next_cs    = 1'b0;
            next_doe_n = 1'b1;
            next_dout  = 1'b0;
            next_state = st_gap;
          end else begin
            next_tx   = {tx[16:0], 1'b0};
            next_dout = tx[16];
            if (cur == read_cmd && bit_cnt >= `RELEASE_BIT) begin
              next_doe_n = 1'b1;
            end
          end
        end
      end
      st_gap: begin
        // select stays low one half period between frames
        if (rise) begin
          if (needs_poll(cur)) begin
            next_cs      = 1'b1;
            next_bit_cnt = 5'h00; // reused as poll settle counter
            next_state   = st_poll;
          end else begin
            next_state = st_finish;
          end
        end
      end
      st_poll: begin
        // released line still shows a stale level until select and synchroniser settle
        if (bit_cnt != `POLL_SETTLE) begin
          next_bit_cnt = bit_cnt + 5'h01;
        end else if (din) begin
          // memory raises its data pin when programming ends
          next_cs    = 1'b0;
          next_state = st_finish;
        end
      end
      st_finish: begin
        next_state = st_idle;
        if (load_run) begin
          if (aborted) begin
            next_load_run = 1'b0;
          end else if (load_idx == 3'h0) begin
            if (rx == `SIG_VALUE) begin
              next_load_idx = 3'h1;
              launch_go     = 1'b1;
              launch_addr   = 7'h01;
            end else begin
              next_load_run = 1'b0;
            end
          end else begin
            case (load_idx)
              3'h1:    next_lo[7:0]   = rx;
              3'h2:    next_lo[15:8]  = rx;
              3'h3:    next_lo[23:16] = rx;
              3'h4:    next_lo[31:24] = rx;
              3'h5:    next_hi[7:0]   = rx;
              default: next_hi[15:8]  = rx;
            endcase
            if (load_idx == `STATION_BYTES) begin
              next_loaded   = 1'b1;
              next_load_run = 1'b0;
            end else begin
              next_load_idx = load_idx + 3'h1;
              launch_go     = 1'b1;
              launch_addr   = {4'h0, load_idx + 3'h1};
            end
          end
        end else if (cur == read_cmd && !aborted) begin
          next_data = rx;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    // response timer abandons the operation
    if (state != st_idle && state != st_finish && to_cnt == TO_W'(TIMEOUT_CYCLES - 1)) begin
      next_state   = st_finish;
      next_cs      = 1'b0;
      next_doe_n   = 1'b1;
      next_dout    = 1'b0;
      next_timeout = 1'b1;
      next_aborted = 1'b1;
    end
    // start a frame with select high and the start bit out
    launch_frame = build_frame(launch_cmd, launch_addr, next_data);
    if (launch_go) begin
      next_state   = st_shift;
      next_cur     = launch_cmd;
      next_tx      = launch_frame;
      next_len     = is_long(launch_cmd) ? `LONG_FRAME : `SHORT_FRAME;
      next_bit_cnt = 5'h00;
      next_to_cnt  = '0;
      next_cs      = 1'b1;
      next_dout    = launch_frame[17];
      next_doe_n   = 1'b0;
    end
    next_busy = (next_state != st_idle) || next_load_pend;
  end

  // register controller state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state                   <= st_idle;
      cur                     <= read_cmd;
      tx                      <= 18'h00000;
      frame_len               <= `SHORT_FRAME;
      bit_cnt                 <= 5'h00;
      rx                      <= 8'h00;
      to_cnt                  <= '0;
      aborted                 <= 1'b0;
      load_pend               <= 1'b1;
      load_run                <= 1'b0;
      load_idx                <= 3'h0;
      cs                      <= 1'b0;
      dout                    <= 1'b0;
      doe_n                   <= 1'b1;
      serial_mem_data_reg     <= `DATA_RST;
      station_addr_lower      <= `STATION_LO_RST;
      station_addr_upper      <= `STATION_HI_RST;
      station_addr_loaded_bit <= 1'b0;
      response_timeout_bit    <= 1'b0;
      operation_busy_bit      <= 1'b1;
    end else begin
      state                   <= next_state;
      cur                     <= next_cur;
      tx                      <= next_tx;
      frame_len               <= next_len;
      bit_cnt                 <= next_bit_cnt;
      rx                      <= next_rx;
      to_cnt                  <= next_to_cnt;
      aborted                 <= next_aborted;
      load_pend               <= next_load_pend;
      load_run                <= next_load_run;
      load_idx                <= next_load_idx;
      cs                      <= next_cs;
      dout                    <= next_dout;
      doe_n                   <= next_doe_n;
      serial_mem_data_reg     <= next_data;
      station_addr_lower      <= next_lo;
      station_addr_upper      <= next_hi;
      station_addr_loaded_bit <= next_loaded;
      response_timeout_bit    <= next_timeout;
      operation_busy_bit      <= next_busy;
    end
  end

  // pin multiplexer: serial interface or general-purpose outputs
  always_comb begin
    next_clk_pin  = sclk && (state == st_shift);
    next_cs_pin   = cs;
    next_dout_pin = dout;
    next_oe_pin   = doe_n;
    if (!if_enable) begin
      next_clk_pin  = gpio_clk_val;
      next_cs_pin   = 1'b0;
      next_dout_pin = gpio_data_val;
      next_oe_pin   = 1'b0;
    end
  end

  // register pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_mem_clock_pin  <= 1'b0;
      serial_mem_select_pin <= 1'b0;
      serial_mem_data_out   <= 1'b0;
      serial_mem_data_oe_n  <= 1'b1;
    end else begin
      serial_mem_clock_pin  <= next_clk_pin;
      serial_mem_select_pin <= next_cs_pin;
      serial_mem_data_out   <= next_dout_pin;
      serial_mem_data_oe_n  <= next_oe_pin;
    end
  end

  // first auto-load frame reads the signature location
  property p_sig_read;
    @(posedge clk) disable iff (!rst_n)
    $rose(load_run) |-> state == st_shift && tx[17:8] == {1'b1, `OP_READ, `SIG_ADDR};
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("auto-load did not read signature");

  // first address byte lands in the low bits
  property p_byte0;
    @(posedge clk) disable iff (!rst_n)
    (state == st_finish && load_run && !aborted && load_idx == 3'h1) |=> station_addr_lower[7:0] == $past(rx);
  endproperty
  a_byte0: assert property (p_byte0) else $error("station byte 0 not stored");

  // loaded bit rises only after the sixth byte
  property p_loaded;
    @(posedge clk) disable iff (!rst_n)
    $rose(station_addr_loaded_bit) |-> $past(load_idx) == `STATION_BYTES && $past(state) == st_finish;
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded bit set early");

  // wrong signature ends the load with nothing loaded
  property p_bad_sig;
    @(posedge clk) disable iff (!rst_n)
    (state == st_finish && load_run && !aborted && load_idx == 3'h0 && rx != `SIG_VALUE)
      |=> !load_run && !station_addr_loaded_bit && $stable(station_addr_lower);
  endproperty
  a_bad_sig: assert property (p_bad_sig) else $error("bad signature still loaded");

  // accepted command raises busy; busy falls only when idle
  property p_busy;
    @(posedge clk) disable iff (!rst_n)
    (state == st_idle && !load_pend && cmd_start && if_enable && !soft_reset_req) |=> operation_busy_bit;
  endproperty
  a_busy: assert property (p_busy) else $error("start did not set busy");

  property p_busy_end;
    @(posedge clk) disable iff (!rst_n)
    $fell(operation_busy_bit) |-> state == st_idle && $past(state) == st_finish;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy cleared before completion");

  // read result in data register when busy clears
  property p_read_data;
    @(posedge clk) disable iff (!rst_n)
    (state == st_finish && !load_run && cur == read_cmd && !aborted) |=> serial_mem_data_reg == $past(rx);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not returned");

  // timer expiry sets the timeout bit and ends the operation
  property p_timeout;
    @(posedge clk) disable iff (!rst_n)
    (state != st_idle && state != st_finish && to_cnt == TO_W'(TIMEOUT_CYCLES - 1))
      |=> response_timeout_bit && state == st_finish ##1 state == st_idle;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  // frame ends after exactly its serial clock count
  property p_frame_len;
    @(posedge clk) disable iff (!rst_n)
    (state == st_shift && fall && bit_cnt == frame_len)
      |-> frame_len == (is_long(cur) ? `LONG_FRAME : `SHORT_FRAME) ##1 state == st_gap && !cs;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  // disabled interface hands pins to general-purpose values
  property p_gpio;
    @(posedge clk) disable iff (!rst_n)
    !if_enable |=> serial_mem_clock_pin == $past(gpio_clk_val) && !serial_mem_select_pin && !serial_mem_data_oe_n;
  endproperty
  a_gpio: assert property (p_gpio) else $error("pins not released to gpio");

endmodule // serial_eeprom_controller

/* File: rtl/serial_mem_cfg.svh */
// Purpose: constants of the serial memory controller (timing, frame layout, reset values)
// Assumes: 50 MHz system clock
// Notes:   included by bare name; definitions only
`ifndef SERIAL_MEM_CFG_SVH
`define SERIAL_MEM_CFG_SVH

// timing
`define CLK_PERIOD_NS       20
`define RESP_TIMEOUT_MS     30
`define RESP_TIMEOUT_CYCLES ((`RESP_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYCLES    25
// cycles the poll ignores the data pin after select rises (pin register plus synchroniser lag)
`define POLL_SETTLE         5'h04

// signature and station address load
`define SIG_ADDR            7'h00
`define SIG_VALUE           8'hA5
`define STATION_BYTES       3'h6

// frame lengths in serial clock cycles and bit positions
`define SHORT_FRAME         5'h0A
`define LONG_FRAME          5'h12
`define RELEASE_BIT         5'h0A
`define FIRST_SAMPLE_BIT    5'h0B

// serial opcodes and extended-opcode address bits
`define OP_READ             2'h2
`define OP_WRITE            2'h1
`define OP_ERASE            2'h3
`define OP_EXT              2'h0
`define EXT_MODIFY_ENABLE_CMD            2'h3
`define EXT_MODIFY_DISABLE_CMD            2'h0
`define EXT_ERASE_EVERYTHING_CMD            2'h2
`define EXT_WRITE_EVERYTHING_CMD            2'h1

// reset values
`define DATA_RST            8'h00
`define STATION_LO_RST      32'h00000000
`define STATION_HI_RST      16'h0000

`endif

/* File: rtl/serial_mem_pkg.sv */
// Purpose: types shared by the serial memory controller files
// Assumes: nothing
// Notes:   host command codes and controller states
package serial_mem_pkg;

  // host command codes carried in the operation code field
  typedef enum logic [2:0] {
    read_cmd             = 3'h0,
    modify_disable_cmd   = 3'h1,
    modify_enable_cmd    = 3'h2,
    write_cmd            = 3'h3,
    write_everything_cmd = 3'h4,
    erase_cmd            = 3'h5,
    erase_everything_cmd = 3'h6,
    reload_cmd           = 3'h7
  } host_cmd_type;

  // controller states, gray coded along idle-shift-gap-poll-finish
  typedef enum logic [2:0] {
    st_idle   = 3'h0,
    st_shift  = 3'h1,
    st_gap    = 3'h3,
    st_poll   = 3'h2,
    st_finish = 3'h6
  } ctl_state_type;

endpackage

/* File: rtl/pin_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage feeds only the second stage
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronised out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;  // metastability catcher

  // two stages, nothing reads stage_one but stage two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // pin_sync

/* File: rtl/serial_clk_gen.sv */
// Purpose: serial memory clock divider with edge pulses
// Assumes: run held high for the whole time a clock is wanted
// Notes:   clock restarts low with a fresh half period when run drops
module serial_clk_gen #(
  parameter int HALF_CYCLES = 25
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic run,
  // divided clock and one-cycle edge pulses
  output logic      sclk,
  output logic      rise,
  output logic      fall
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] cnt;       // half-period counter
  logic [CW-1:0] next_cnt;  // next counter value
  logic          next_sclk; // next clock level
  logic          next_rise; // next rise pulse
  logic          next_fall; // next fall pulse

  // divide and mark edges
  always_comb begin
    next_cnt  = '0;
    next_sclk = 1'b0;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (run) begin
      next_sclk = sclk;
      if (cnt == CW'(HALF_CYCLES - 1)) begin
        next_sclk = !sclk;
        next_rise = !sclk;
        next_fall = sclk;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // register divider state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      sclk <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      sclk <= next_sclk;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

endmodule // serial_clk_gen

/* File: sim/mem_model.sv */
// Purpose: three-wire 128 x 8 serial memory model
// Assumes: bits shift in on clock rise while select is high
// Notes:   busy counts 20 ns steps of program time
module mem_model (
  // serial pins
  input  wire logic sck,
  input  wire logic cs,
  input  wire logic di,
  output logic      so
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [128]; // contents
  logic [17:0] sr;        // frame shift register
  logic [6:0]  a;         // read address
  logic        wen, rd, pend;
  int          n = 0, len = 0, busy = 10;
  // preset contents, signature at location 0, modify disabled
  initial begin
    so = 1'b1;
    wen = 1'b0;
    rd = 1'b0;
    pend = 1'b0;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hA5;
  end
  // shift in, then a dummy zero and read data msb first
  always @(posedge sck) if (cs) begin
    sr = {sr[16:0], di};
    n++;
    if (n == 10) begin
      a = sr[6:0];
      rd = sr[9:7] == 3'b110;
    end
    if (rd && n >= 10) so = n == 10 ? 1'b0 : mem[a][18-n];
  end
  // decode a finished frame; released line flips its level
  always @(negedge cs) begin
    if (n != 0) len = n;
    if (n == 10 && wen && sr[8:7] == 2'h3) mem[sr[6:0]] = 8'hFF;
    if (n == 10 && wen && sr[8:5] == 4'h2) foreach (mem[i]) mem[i] = 8'hFF;
    if (n == 10 && sr[8:5] == 4'h3) wen = 1'b1;
    if (n == 10 && sr[8:5] == 4'h0) wen = 1'b0;
    if (n == 18 && wen && sr[16:15] == 2'h1) mem[sr[14:8]] = sr[7:0];
    if (n == 18 && wen && sr[16:13] == 4'h1) foreach (mem[i]) mem[i] = sr[7:0];
    pend = n == 10 ? sr[8] | (sr[8:5] == 4'h2) : n == 18 && sr[16:15] != 2'h2;
    so = ~so;
    n = 0;
  end
  // program step: line low until done or select drops
  always @(posedge cs) if (pend) begin
    so = 1'b0;
    for (int k = 0; k < busy && cs; k++) #20;
    so = 1'b1;
    pend = 1'b0;
  end
endmodule // mem_model

/* File: sim/tb_serial_eeprom_controller.sv */
// Purpose: self-checking bench for the serial memory controller
// Assumes: inputs change at the falling clock edge
// Notes:   short timeout and a 160 ns serial clock
module tb_serial_eeprom_controller;
  import serial_mem_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, soft_reset_req = 0, cmd_start = 0, data_wr_en = 0, timeout_clear = 0;
  logic if_enable = 1, gpio_data_val = 1, gpio_clk_val = 1;
  host_cmd_type operation_code_field = read_cmd;
  logic [6:0] location_field = 7'h00;
  logic [7:0] data_wr_value = 8'h00;
  wire operation_busy_bit, response_timeout_bit, station_addr_loaded_bit, serial_mem_clock_pin, so;
  wire serial_mem_select_pin, serial_mem_data_out, serial_mem_data_oe_n;
  wire [7:0] serial_mem_data_reg;
  wire [31:0] station_addr_lower;
  wire [15:0] station_addr_upper;
  wire serial_mem_data_in = serial_mem_data_oe_n ? so : serial_mem_data_out;
  int failures = 0, n_compared = 0;
  always #10 clk = ~clk;
  serial_eeprom_controller #(.TIMEOUT_CYCLES(2000), .SCLK_HALF(4)) u_dut (.*);
  mem_model u_mem (.sck(serial_mem_clock_pin), .cs(serial_mem_select_pin), .di(serial_mem_data_in), .so(so));
  // compare and count
  task chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // summary and end of run
  task give_verdict;
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for the busy bit to drop
  task idle;
    int k;
    for (k = 0; k < 5000 && operation_busy_bit !== 1'b0; k++) @(negedge clk);
    if (k == 5000) failures++;
    if (k == 5000) give_verdict();
  endtask
  // load data, start a command, wait for completion
  task op(input host_cmd_type c, input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    data_wr_en = 1'b1;
    data_wr_value = d;
    @(negedge clk);
    data_wr_en = 1'b0;
    operation_code_field = c;
    location_field = a;
    cmd_start = 1'b1;
    @(negedge clk);
    cmd_start = 1'b0;
    chk("busy", operation_busy_bit, 1'b1);
    idle();
    chk("frame", u_mem.len, c inside {read_cmd, write_cmd, write_everything_cmd, reload_cmd} ? 18 : 10);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] exp);
    op(read_cmd, a, 8'h00);
    chk("read", serial_mem_data_reg, exp);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    idle();
    chk("loaded", station_addr_loaded_bit, 1'b1);
    chk("station", {station_addr_upper, station_addr_lower}, 48'hA3A0A1A6A7A4);
    rd(7'h05, 8'hA0);
    op(modify_enable_cmd, 7'h00, 8'h00);
    op(write_cmd, 7'h09, 8'h3C);
    rd(7'h09, 8'h3C);
    op(erase_cmd, 7'h09, 8'h00);
    rd(7'h09, 8'hFF);
    op(write_everything_cmd, 7'h00, 8'h5A);
    rd(7'h7F, 8'h5A);
    op(erase_everything_cmd, 7'h00, 8'h00);
    rd(7'h00, 8'hFF);
    op(modify_disable_cmd, 7'h00, 8'h00);
    op(write_cmd, 7'h01, 8'h77);
    rd(7'h01, 8'hFF);
    soft_reset_req = 1'b1;
    @(negedge clk);
    soft_reset_req = 1'b0;
    @(negedge clk);
    idle();
    chk("no load", station_addr_loaded_bit, 1'b0);
    chk("kept", {station_addr_upper, station_addr_lower}, 48'hA3A0A1A6A7A4);
    op(modify_enable_cmd, 7'h00, 8'h00);
    op(write_cmd, 7'h00, 8'hA5);
    op(reload_cmd, 7'h00, 8'h00);
    chk("reload", station_addr_loaded_bit, 1'b1);
    chk("reloaded", {station_addr_upper, station_addr_lower}, 48'hFFFFFFFFFFFF);
    u_mem.busy = 3000;
    op(write_cmd, 7'h02, 8'h00);
    chk("timeout", response_timeout_bit, 1'b1);
    timeout_clear = 1'b1;
    @(negedge clk);
    timeout_clear = 1'b0;
    @(negedge clk);
    chk("cleared", response_timeout_bit, 1'b0);
    if_enable = 1'b0;
    gpio_data_val = 1'b0;
    repeat (3) @(negedge clk);
    chk("gpio", {serial_mem_clock_pin, serial_mem_data_out, serial_mem_select_pin, serial_mem_data_oe_n}, 4'b1000);
    give_verdict();
  end
endmodule // tb_serial_eeprom_controller
